/* File: src/sbf_defines.vh */
`ifndef SBF_DEFINES_VH
`define SBF_DEFINES_VH
// register byte offsets
`define SBF_A_CTRL       8'h00
`define SBF_A_FREF       8'h04
`define SBF_A_START      8'h08
`define SBF_A_MAX        8'h0c
`define SBF_A_LIM_LO     8'h10
`define SBF_A_LIM_HI     8'h14
`define SBF_A_DCB_FREQ   8'h18
`define SBF_A_DCB_BLOCK  8'h1c
`define SBF_A_DCB_TIME   8'h20
`define SBF_A_DCB_LEVEL  8'h24
`define SBF_A_DWELL_FREQ 8'h28
`define SBF_A_DWELL_TIME 8'h2c
`define SBF_A_ACC_STEP   8'h30
`define SBF_A_DEC_STEP   8'h34
`define SBF_A_STATUS     8'h38
`define SBF_A_OUT_FREQ   8'h3c
// ctrl fields
`define SBF_C_RUN        0
`define SBF_C_MODE_LO    4
`define SBF_C_MODE_HI    6
`define SBF_C_LIM_EN     8
`define SBF_C_STALL_EN   9
// status fields
`define SBF_S_DONE       4
// stop modes
`define SBF_M_DEC        3'h0
`define SBF_M_DCB        3'h1
`define SBF_M_FREE       3'h2
`define SBF_M_PB         3'h4
// reset values, frequencies in 0.01 Hz, times in 0.01 s
`define SBF_R_START      16'h0032
`define SBF_R_MAX        16'h1770
`define SBF_R_LIM_LO     16'h0032
`define SBF_R_DCB_FREQ   16'h01f4
`define SBF_R_DCB_BLOCK  16'h000a
`define SBF_R_DCB_TIME   16'h0064
`define SBF_R_DCB_LEVEL  8'h32
`define SBF_R_STEP       16'h000a
// legal ranges
`define SBF_START_MIN    16'h0001
`define SBF_START_MAX    16'h03e8
`define SBF_MAX_MIN      16'h0fa0
`define SBF_MAX_MAX      16'h9c40
`define SBF_DCB_F_MAX    16'h1770
`define SBF_TIME_MAX     16'h1770
`define SBF_LEVEL_MAX    8'hc8
// timing: one tick is 0.01 s at 25 MHz
`define SBF_TICK_CYCLES  18'd250000
`endif

/* File: src/sbf_freq_clamp.v */
`timescale 1ns/100ps
`default_nettype none
module sbf_freq_clamp (
  // reference and limits
  input  wire [15:0] ref_in,
  input  wire [15:0] start_freq,
  input  wire [15:0] max_freq,
  input  wire [15:0] lim_lo,
  input  wire [15:0] lim_hi,
  input  wire        lim_en,
  // result
  output reg  [15:0] ref_out
);
  reg [15:0] hi_eff;
  reg [15:0] lo_eff;
  reg [15:0] v;
  always @* begin
    hi_eff = (lim_hi > max_freq) ? max_freq : lim_hi;
    if (hi_eff < lim_lo) begin
      hi_eff = lim_lo;
    end
    lo_eff = (lim_lo > max_freq) ? max_freq : lim_lo;
    v = (ref_in > max_freq) ? max_freq : ref_in;
    if (lim_en) begin
      if (v < lo_eff) begin
        v = lo_eff;
      end
      if (v > hi_eff) begin
        v = hi_eff;
      end
    end
    ref_out = (v < start_freq) ? 16'h0000 : v;
  end
endmodule
`default_nettype wire

/* File: src/sbf_stop_brake.v */
// Contract
// - dc-brake mode: decelerate, then inject dc
// - output blocked for pre-brake interval first
// - inject dc for braking duration, then end
// - braking amount percent of rated current
// - dc-brake start frequency configurable, default 5 Hz
// - dwell below brake frequency is skipped
// - free-run: output off at run removal
// - mode 4: bus high slows or re-accelerates
// - power braking beats stall, decel only
// - reference below start frequency becomes zero; code tests it after the limit clamp, so an enabled lower limit can lift it
// - max frequency caps all, rejects higher settings
// - limit enable off by default, exposes limits
// - enabled limits clamp every frequency selection
// - mode 0: ramp to zero then stop
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`include "sbf_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module sbf_stop_brake #(
  parameter [17:0] TICK_CYCLES = `SBF_TICK_CYCLES
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // drive feedback pins
  input  wire        dcbus_high_in,
  input  wire        stall_req_in,
  // output stage
  output reg  [15:0] out_freq,
  output reg         out_enable,
  output reg         dc_inject,
  output reg  [7:0]  dc_level,
  output reg         stop_done,
  output reg         pbrake_active,
  output reg         stall_active
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RUN   = 3'h1;
  localparam [2:0] ST_DECEL = 3'h2;
  localparam [2:0] ST_DWELL = 3'h3;
  localparam [2:0] ST_BLOCK = 3'h4;
  localparam [2:0] ST_DCINJ = 3'h5;
  localparam [2:0] ST_DONE  = 3'h6;

  reg        run_q;
  reg [2:0]  mode_q;
  reg        lim_en_q;
  reg        stall_en_q;
  reg [15:0] fref_q;
  reg [15:0] start_q;
  reg [15:0] max_q;
  reg [15:0] lo_q;
  reg [15:0] hi_q;
  reg [15:0] dcb_freq_q;
  reg [15:0] dcb_block_q;
  reg [15:0] dcb_time_q;
  reg [7:0]  dcb_level_q;
  reg [15:0] dwell_freq_q;
  reg [15:0] dwell_time_q;
  reg [15:0] acc_q;
  reg [15:0] dec_q;
  reg        done_flag_q;
  reg        wr_pend_q;
  reg [7:0]  wr_addr_q;
  reg [2:0]  state_q;
  reg [15:0] cnt_q;
  reg        dwell_done_q;
  reg [17:0] tick_cnt_q;
  reg        tick_q;
  reg [1:0]  bus_sync_q;
  reg [1:0]  stall_sync_q;
  reg [31:0] rd_mux;
  wire [15:0] ref_clamped;
  wire        acc_en;
  wire        wr_en;
  wire [15:0] wv;
  wire        bus_high;
  wire        stall_req;
  wire [16:0] up_sum;
  wire [15:0] dn_val;
  wire [15:0] up_val;
  wire [15:0] hi_floor;

  assign acc_en    = hsel & htrans[1] & hready;
  assign wr_en     = wr_pend_q;
  assign wv        = hwdata[15:0];
  assign bus_high  = bus_sync_q[1];
  assign stall_req = stall_sync_q[1];
  assign up_sum    = {1'b0, out_freq} + {1'b0, acc_q};
  assign up_val    = (up_sum[16] || up_sum[15:0] > max_q) ? max_q : up_sum[15:0];
  assign dn_val    = (out_freq > dec_q) ? out_freq - dec_q : 16'h0000;
  assign hi_floor  = lim_en_q ? lo_q : 16'h0000;

  sbf_freq_clamp u_clamp (
    .ref_in     (fref_q),
    .start_freq (start_q),
    .max_freq   (max_q),
    .lim_lo     (lo_q),
    .lim_hi     (hi_q),
    .lim_en     (lim_en_q),
    .ref_out    (ref_clamped)
  );

  // pins from the power stage are asynchronous to hclk
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_sync_q   <= 2'h0;
      stall_sync_q <= 2'h0;
    end else begin
      bus_sync_q   <= {bus_sync_q[0], dcbus_high_in};
      stall_sync_q <= {stall_sync_q[0], stall_req_in};
    end
  end

  // 0.01 s tick enable; all ramps and timers count in ticks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 18'h00000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYCLES - 18'h00001) begin
      tick_cnt_q <= 18'h00000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
      tick_q     <= 1'b0;
    end
  end

  always @* begin
    case (haddr[7:0])
      `SBF_A_CTRL:       rd_mux = {22'h000000, stall_en_q, lim_en_q, 1'b0, mode_q, 3'h0, run_q};
      `SBF_A_FREF:       rd_mux = {16'h0000, fref_q};
      `SBF_A_START:      rd_mux = {16'h0000, start_q};
      `SBF_A_MAX:        rd_mux = {16'h0000, max_q};
      `SBF_A_LIM_LO:     rd_mux = lim_en_q ? {16'h0000, lo_q} : 32'h00000000;
      `SBF_A_LIM_HI:     rd_mux = lim_en_q ? {16'h0000, hi_q} : 32'h00000000;
      `SBF_A_DCB_FREQ:   rd_mux = {16'h0000, dcb_freq_q};
      `SBF_A_DCB_BLOCK:  rd_mux = {16'h0000, dcb_block_q};
      `SBF_A_DCB_TIME:   rd_mux = {16'h0000, dcb_time_q};
      `SBF_A_DCB_LEVEL:  rd_mux = {24'h000000, dcb_level_q};
      `SBF_A_DWELL_FREQ: rd_mux = {16'h0000, dwell_freq_q};
      `SBF_A_DWELL_TIME: rd_mux = {16'h0000, dwell_time_q};
      `SBF_A_ACC_STEP:   rd_mux = {16'h0000, acc_q};
      `SBF_A_DEC_STEP:   rd_mux = {16'h0000, dec_q};
      `SBF_A_STATUS:     rd_mux = {23'h000000, dc_inject, out_enable, stall_active,
                                   pbrake_active, done_flag_q, 1'b0, state_q};
      `SBF_A_OUT_FREQ:   rd_mux = {16'h0000, out_freq};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // zero-wait slave: read data registered at the address phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= acc_en & hwrite;
      if (acc_en) begin
        wr_addr_q <= haddr[7:0];
        hrdata    <= hwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // settings out of range are dropped, the old value stays
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q        <= 1'b0;
      mode_q       <= `SBF_M_DEC;
      lim_en_q     <= 1'b0;
      stall_en_q   <= 1'b0;
      fref_q       <= 16'h0000;
      start_q      <= `SBF_R_START;
      max_q        <= `SBF_R_MAX;
      lo_q         <= `SBF_R_LIM_LO;
      hi_q         <= `SBF_R_MAX;
      dcb_freq_q   <= `SBF_R_DCB_FREQ;
      dcb_block_q  <= `SBF_R_DCB_BLOCK;
      dcb_time_q   <= `SBF_R_DCB_TIME;
      dcb_level_q  <= `SBF_R_DCB_LEVEL;
      dwell_freq_q <= 16'h0000;
      dwell_time_q <= 16'h0000;
      acc_q        <= `SBF_R_STEP;
      dec_q        <= `SBF_R_STEP;
    end else if (wr_en) begin
      case (wr_addr_q)
        `SBF_A_CTRL: begin
          run_q      <= hwdata[`SBF_C_RUN];
          mode_q     <= hwdata[`SBF_C_MODE_HI:`SBF_C_MODE_LO];
          lim_en_q   <= hwdata[`SBF_C_LIM_EN];
          stall_en_q <= hwdata[`SBF_C_STALL_EN];
        end
        `SBF_A_FREF: begin
          if (wv <= max_q) fref_q <= wv;
        end
        `SBF_A_START: begin
          if (wv >= `SBF_START_MIN && wv <= `SBF_START_MAX && wv <= max_q) start_q <= wv;
        end
        `SBF_A_MAX: begin
          if (wv >= `SBF_MAX_MIN && wv <= `SBF_MAX_MAX) max_q <= wv;
        end
        `SBF_A_LIM_LO: begin
          if (lim_en_q && wv <= max_q) lo_q <= wv;
        end
        `SBF_A_LIM_HI: begin
          if (lim_en_q && wv >= hi_floor && wv <= max_q) hi_q <= wv;
        end
        `SBF_A_DCB_FREQ: begin
          if (wv <= `SBF_DCB_F_MAX && wv <= max_q) dcb_freq_q <= wv;
        end
        `SBF_A_DCB_BLOCK: begin
          if (wv <= `SBF_TIME_MAX) dcb_block_q <= wv;
        end
        `SBF_A_DCB_TIME: begin
          if (wv <= `SBF_TIME_MAX) dcb_time_q <= wv;
        end
        `SBF_A_DCB_LEVEL: begin
          if (wv <= {8'h00, `SBF_LEVEL_MAX}) dcb_level_q <= wv[7:0];
        end
        `SBF_A_DWELL_FREQ: begin
          if (wv <= max_q) dwell_freq_q <= wv;
        end
        `SBF_A_DWELL_TIME: begin
          if (wv <= `SBF_TIME_MAX) dwell_time_q <= wv;
        end
        `SBF_A_ACC_STEP: acc_q <= wv;
        `SBF_A_DEC_STEP: dec_q <= wv;
        default: ;
      endcase
    end
  end

  // sticky done; a completion in the clearing cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_flag_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      done_flag_q <= 1'b1;
    end else if (wr_en && wr_addr_q == `SBF_A_STATUS && hwdata[`SBF_S_DONE]) begin
      done_flag_q <= 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q       <= ST_IDLE;
      cnt_q         <= 16'h0000;
      dwell_done_q  <= 1'b0;
      out_freq      <= 16'h0000;
      out_enable    <= 1'b0;
      dc_inject     <= 1'b0;
      dc_level      <= 8'h00;
      stop_done     <= 1'b0;
      pbrake_active <= 1'b0;
      stall_active  <= 1'b0;
    end else begin
      stop_done     <= 1'b0;
      pbrake_active <= 1'b0;
      stall_active  <= 1'b0;
      if (tick_q) cnt_q <= cnt_q + 16'h0001;
      case (state_q)
        ST_IDLE: begin
          out_freq     <= 16'h0000;
          out_enable   <= 1'b0;
          dc_inject    <= 1'b0;
          dwell_done_q <= 1'b0;
          if (run_q && ref_clamped != 16'h0000) begin
            out_freq   <= start_q;
            out_enable <= 1'b1;
            state_q    <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_q) begin
            if (mode_q == `SBF_M_FREE) begin
              out_freq   <= 16'h0000;
              out_enable <= 1'b0;
              state_q    <= ST_DONE;
            end else begin
              state_q <= ST_DECEL;
            end
          end else if (tick_q) begin
            if (out_freq < ref_clamped) begin
              out_freq <= (up_val > ref_clamped) ? ref_clamped : up_val;
            end else begin
              out_freq <= (dn_val < ref_clamped) ? ref_clamped : dn_val;
            end
          end
        end
        ST_DECEL: begin
          if (run_q) begin
            state_q <= ST_RUN;
          end else if (mode_q == `SBF_M_DCB && out_freq <= dcb_freq_q) begin
            out_freq   <= 16'h0000;
            out_enable <= 1'b0;
            cnt_q      <= 16'h0000;
            state_q    <= ST_BLOCK;
          end else if (!dwell_done_q && dwell_time_q != 16'h0000 &&
                       out_freq <= dwell_freq_q &&
                       !(mode_q == `SBF_M_DCB && dwell_freq_q < dcb_freq_q)) begin
            cnt_q   <= 16'h0000;
            state_q <= ST_DWELL;
          end else if (mode_q == `SBF_M_PB && bus_high) begin
            pbrake_active <= 1'b1;
            if (tick_q) begin
              out_freq <= up_val;
            end
          end else if (stall_en_q && stall_req) begin
            stall_active <= 1'b1;
          end else if (tick_q) begin
            if (dn_val < start_q) begin
              out_freq   <= 16'h0000;
              out_enable <= 1'b0;
              state_q    <= ST_DONE;
            end else begin
              out_freq <= dn_val;
            end
          end
        end
        ST_DWELL: begin
          if (cnt_q >= dwell_time_q) begin
            dwell_done_q <= 1'b1;
            state_q      <= ST_DECEL;
          end
        end
        ST_BLOCK: begin
          // a free-spinning rotor must demagnetise before dc goes on
          if (cnt_q >= dcb_block_q) begin
            cnt_q     <= 16'h0000;
            dc_inject <= 1'b1;
            dc_level  <= dcb_level_q;
            state_q   <= ST_DCINJ;
          end
        end
        ST_DCINJ: begin
          if (cnt_q >= dcb_time_q) begin
            dc_inject <= 1'b0;
            dc_level  <= 8'h00;
            state_q   <= ST_DONE;
          end
        end
        ST_DONE: begin
          out_enable <= 1'b0;
          stop_done  <= 1'b1;
          state_q    <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: src/sbf_placeholder_never.v */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: verif/sbf_stop_brake_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sbf_sva_chk #(
  parameter [17:0] TICK_CYCLES = 18'd10
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus answer
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // output stage
  input wire logic [15:0] out_freq,
  input wire logic        out_enable,
  input wire logic        dc_inject,
  input wire logic [7:0]  dc_level,
  input wire logic        stop_done,
  input wire logic        pbrake_active,
  input wire logic        stall_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  level_when_off_a: assert property (!dc_inject |-> dc_level == 8'h00)
    else $error("braking level shown without injection");
  level_range_a: assert property (dc_inject |-> dc_level <= 8'hc8)
    else $error("braking level above range");
  inject_blocked_a: assert property (dc_inject |-> !out_enable && out_freq == 16'h0000)
    else $error("injection while the stage switches");
  pre_block_a: assert property ($rose(dc_inject) |-> !$past(out_enable))
    else $error("injection without a blocked interval");
  done_pulse_a: assert property (stop_done |=> !stop_done)
    else $error("stop done longer than one cycle");
  done_off_a: assert property (stop_done |-> !out_enable && !dc_inject)
    else $error("stop done with output live");
  inject_end_a: assert property ($fell(dc_inject) |-> ##[0:2] stop_done)
    else $error("braking ended without stop done");
  pb_over_stall_a: assert property (pbrake_active |-> !stall_active)
    else $error("stall hold during power braking");
  pb_running_a: assert property (pbrake_active |-> out_enable)
    else $error("power braking with stage off");
  stall_hold_a: assert property (stall_active && $past(stall_active) |-> $stable(out_freq))
    else $error("frequency moved during stall hold");
  max_cap_a: assert property (out_freq <= 16'h9c40)
    else $error("output above top frequency");
  start_floor_a: assert property (out_enable |-> out_freq != 16'h0000)
    else $error("stage on at zero frequency");
endmodule
`default_nettype wire

/* File: verif/sbf_motor_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sbf_motor_model (
  // drive side
  input  wire logic hclk,
  input  wire logic out_enable,
  // bench commands
  input  wire logic regen_on,
  input  wire logic load_heavy,
  // feedback
  output var  logic dcbus_high_in,
  output var  logic stall_req_in
);
  // a coasting motor with the stage off cannot pump the bus or stall
  always @(posedge hclk) begin
    dcbus_high_in <= regen_on & out_enable;
    stall_req_in  <= load_heavy & out_enable;
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sbf_defines.vh"
module tb_top;
  localparam int TK = 10;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        dcb_hi;
  logic        stall_rq;
  logic        regen_on = 1'b0;
  logic        load_heavy = 1'b0;
  logic [15:0] out_freq;
  logic        out_enable;
  logic        dc_inject;
  logic [7:0]  dc_level;
  logic        stop_done;
  logic        pbrake_active;
  logic        stall_active;
  logic        rd_dp = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          bad_count = 0;
  int          n_tests = 0;

  always #20 hclk = ~hclk;

  sbf_stop_brake #(.TICK_CYCLES(18'd10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dcbus_high_in(dcb_hi), .stall_req_in(stall_rq), .out_freq(out_freq),
    .out_enable(out_enable), .dc_inject(dc_inject), .dc_level(dc_level),
    .stop_done(stop_done), .pbrake_active(pbrake_active), .stall_active(stall_active));

  sbf_motor_model motor (.hclk(hclk), .out_enable(out_enable), .regen_on(regen_on),
    .load_heavy(load_heavy), .dcbus_high_in(dcb_hi), .stall_req_in(stall_rq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !wr;
    if (!wr) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_dp  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, e, m);
  endtask

  // read data is judged by whoever sees it, against the oldest note
  always @(posedge hclk)
    if (rd_dp && hreadyout === 1'b1) chk(hrdata & msk_q.pop_front(), exp_q.pop_front());

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    bad_count++;
    conclude();
  end

  initial begin
    logic [7:0]  ra[8] = '{8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h10, 8'h40};
    logic [15:0] rv[8] = '{16'd50, 16'd6000, 16'd500, 16'd10, 16'd100, 16'd50, 16'd0, 16'd0};
    logic [7:0]  wa[6] = '{8'h0c, 8'h0c, 8'h08, 8'h24, 8'h20, 8'h04};
    logic [15:0] wd[6] = '{16'd40001, 16'd3999, 16'd1001, 16'd201, 16'd6001, 16'd6001};
    logic [15:0] f;
    logic [7:0]  lv;
    int          t0;
    int          cnt;
    void'($urandom(32'hdc82b3c6));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], {16'h0, rv[i]}, 32'hffff);
    $display("test 1 done");
    // out-of-range writes must leave the old value in place
    foreach (wa[i]) wr(wa[i], {16'h0, wd[i]});
    foreach (wa[i]) rd(wa[i], {16'h0, rv[i < 2 ? 1 : (i == 2 ? 0 : (i == 4 ? 4 : i + 2))]},
                       32'hffff);
    $display("test 2 done");
    wr(8'h30, 32'd500);
    wr(8'h34, 32'd500);
    wr(8'h04, 32'd30);
    wr(8'h00, 32'h001);
    repeat (5 * TK) @(posedge hclk);
    rd(8'h3c, 32'h0, 32'hffff);
    wr(8'h00, 32'h100);
    wr(8'h10, 32'd1000);
    wr(8'h14, 32'd2000);
    wr(8'h14, 32'd900);
    rd(8'h14, 32'd2000, 32'hffff);
    rd(8'h10, 32'd1000, 32'hffff);
    f = 16'($urandom_range(6000));
    wr(8'h04, {16'h0, f});
    wr(8'h00, 32'h101);
    repeat (20 * TK) @(posedge hclk);
    rd(8'h3c, f < 1000 ? 32'd1000 : (f > 2000 ? 32'd2000 : {16'h0, f}), 32'hffff);
    wr(8'h00, 32'h100);
    while (stop_done !== 1'b1) @(posedge hclk);
    rd(8'h3c, 32'h0, 32'hffff);
    wr(8'h38, 32'h10);
    $display("test 3 done");
    wr(8'h00, 32'h121);
    repeat (10 * TK) @(posedge hclk);
    wr(8'h00, 32'h120);
    rd(8'h3c, 32'h0, 32'hffff);
    rd(8'h38, 32'h10, 32'h90);
    wr(8'h38, 32'h10);
    $display("test 4 done");
    lv = 8'($urandom_range(200));
    wr(8'h1c, 32'd2);
    wr(8'h20, 32'd3);
    wr(8'h24, {24'h0, lv});
    wr(8'h28, 32'd400);
    wr(8'h2c, 32'd5);
    wr(8'h04, 32'd2000);
    wr(8'h00, 32'h111);
    repeat (10 * TK) @(posedge hclk);
    wr(8'h00, 32'h110);
    cnt = 0;
    while (out_enable !== 1'b0) begin
      @(posedge hclk);
      cnt++;
    end
    chk(32'(cnt <= 6 * TK), 32'h1);
    t0 = 0;
    while (dc_inject !== 1'b1) begin
      @(posedge hclk);
      t0++;
    end
    chk(32'(t0 >= TK + 1 && t0 <= 3 * TK + 1), 32'h1);
    @(negedge hclk);
    chk({24'h0, dc_level}, {24'h0, lv});
    cnt = 0;
    while (dc_inject === 1'b1) begin
      @(posedge hclk);
      cnt++;
    end
    chk(32'(cnt >= 2 * TK && cnt <= 3 * TK + 1), 32'h1);
    rd(8'h38, 32'h10, 32'h190);
    wr(8'h38, 32'h10);
    $display("test 5 done");
    wr(8'h34, 32'd50);
    wr(8'h00, 32'h341);
    repeat (10 * TK) @(posedge hclk);
    regen_on <= 1'b1;
    load_heavy <= 1'b1;
    wr(8'h00, 32'h340);
    repeat (3 * TK) @(posedge hclk);
    f = out_freq;
    repeat (3 * TK) @(posedge hclk);
    chk(32'(out_freq > f), 32'h1);
    rd(8'h38, 32'h20, 32'h60);
    regen_on <= 1'b0;
    repeat (3 * TK) @(posedge hclk);
    rd(8'h38, 32'h40, 32'h60);
    load_heavy <= 1'b0;
    while (stop_done !== 1'b1) @(posedge hclk);
    rd(8'h3c, 32'h0, 32'hffff);
    $display("test 6 done");
    conclude();
  end
endmodule

bind sbf_stop_brake sbf_sva_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .out_freq(out_freq), .out_enable(out_enable), .dc_inject(dc_inject), .dc_level(dc_level),
  .stop_done(stop_done), .pbrake_active(pbrake_active), .stall_active(stall_active));
`default_nettype wire
